/* File: verilog/rocr_defines.svh */
`ifndef ROCR_DEFINES_SVH
`define ROCR_DEFINES_SVH
`define ROCR_OFS_DEVID 8'h00
`define ROCR_OFS_RESET 8'h01
`define ROCR_OFS_OUTCFG 8'h02
`define ROCR_OFS_GENCFG 8'h03
`define ROCR_OFS_I2CCTL 8'h05
`define ROCR_RST_RESET 8'h04
`define ROCR_RST_OUTCFG 8'h00
`define ROCR_RST_GENCFG 8'hF0
`define ROCR_RST_I2CCTL 8'h1E
`define ROCR_BIT_KEEP 0
`define ROCR_BIT_FULL 1
`define ROCR_BIT_RCH 2
`define ROCR_BIT_OSC 5
`define ROCR_BIT_OVR 6
`define ROCR_BIT_OE 7
`define ROCR_BIT_OSS 4
`define ROCR_BIT_PT 3
`define ROCR_BIT_PTALL 7
`define ROCR_MASK_RESET 8'h07
`define ROCR_MASK_OUTCFG 8'hF0
`define ROCR_PULSE_CYC 2
`endif

/* File: verilog/rocr_pkg.sv */
package rocr_pkg;
    typedef enum logic [1:0]
    {
        ROCR_RUN = 2'b00,
        ROCR_PULSE = 2'b01
    } rocr_state_t;
endpackage

/* File: verilog/rocr_regs.sv */
`timescale 1ns/1ps
`include "rocr_defines.svh"
module rocr_regs
    import rocr_pkg::*;
#(
    parameter int PULSE_CYC = `ROCR_PULSE_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register access port, arbitrated upstream
    input wire logic wr_en,
    input wire logic wr_remote,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // strap value latched at start-up for the device address register
    input wire logic [7:0] strap_dev_id,
    // link status, asynchronous to clk_sys
    input wire logic lock_pin,
    // block controls
    output logic return_channel_active,
    output logic out_enable_eff,
    output logic unlocked_pin_state,
    output logic fallback_osc_to_pixclk,
    output logic logic_reset_b,
    output logic regs_reset_pulse
);
    // the pulse counter is four bits wide
    if (PULSE_CYC < 1 || PULSE_CYC > 15)
    begin : g_pulse_range
        $error("PULSE_CYC out of range");
    end

    // ************************************************
    // register state
    // ************************************************
    logic return_channel_on;
    logic [7:4] outcfg;
    logic [7:0] gencfg;
    logic [7:0] i2cctl;
    logic [7:0] dev_id;
    logic [7:0] strap_q;
    logic strap_seen;
    logic [2:0] lock_sync;
    logic lock_q;
    rocr_state_t state;
    logic [3:0] pulse_cnt;
    logic pulse_full;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire logic do_wr = wr_en && state == ROCR_RUN;
    wire logic req_full = do_wr && hit(wr_addr, `ROCR_OFS_RESET) && wr_data[`ROCR_BIT_FULL];
    wire logic req_keep = do_wr && hit(wr_addr, `ROCR_OFS_RESET) && wr_data[`ROCR_BIT_KEEP];
    wire logic reg_clear = pulse_full && state == ROCR_PULSE;

    // strap latched once after release; never touched by digital reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            strap_seen <= 1'b0;
            strap_q <= 8'h00;
        end
        else if (!strap_seen)
        begin
            strap_seen <= 1'b1;
            strap_q <= strap_dev_id;
        end
    end

    // ************************************************
    // reset pulse sequencer
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state <= ROCR_RUN;
            pulse_cnt <= 4'h0;
            pulse_full <= 1'b0;
        end
        else
        begin
            case (state)
                ROCR_RUN:
                begin
                    if (req_full || req_keep)
                    begin
                        state <= ROCR_PULSE;
                        pulse_cnt <= 4'(PULSE_CYC - 1);
                        pulse_full <= req_full;
                    end
                end
                ROCR_PULSE:
                begin
                    if (pulse_cnt == 4'h0)
                    begin
                        state <= ROCR_RUN;
                        pulse_full <= 1'b0;
                    end
                    else
                    begin
                        pulse_cnt <= pulse_cnt - 4'h1;
                    end
                end
                default:
                begin
                    state <= ROCR_RUN;
                end
            endcase
        end
    end

    // ************************************************
    // register file
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            return_channel_on <= 1'(`ROCR_RST_RESET >> `ROCR_BIT_RCH);
            outcfg <= 4'(`ROCR_RST_OUTCFG >> 4);
            gencfg <= `ROCR_RST_GENCFG;
            i2cctl <= `ROCR_RST_I2CCTL;
            dev_id <= 8'h00;
        end
        else if (reg_clear)
        begin
            // reset control reloads its reset value with bit 2 set, so the channel enable goes back on
            return_channel_on <= 1'(`ROCR_RST_RESET >> `ROCR_BIT_RCH);
            outcfg <= 4'(`ROCR_RST_OUTCFG >> 4);
            gencfg <= `ROCR_RST_GENCFG;
            i2cctl <= `ROCR_RST_I2CCTL;
            dev_id <= strap_q;
        end
        else if (!strap_seen)
        begin
            dev_id <= strap_dev_id;
        end
        else if (do_wr)
        begin
            if (hit(wr_addr, `ROCR_OFS_RESET))
            begin
                if (wr_data[`ROCR_BIT_RCH] || !wr_remote)
                begin
                    return_channel_on <= wr_data[`ROCR_BIT_RCH];
                end
            end
            if (hit(wr_addr, `ROCR_OFS_OUTCFG))
            begin
                outcfg <= wr_data[7:4];
            end
            if (hit(wr_addr, `ROCR_OFS_GENCFG))
            begin
                gencfg <= wr_data;
            end
            if (hit(wr_addr, `ROCR_OFS_I2CCTL))
            begin
                i2cctl <= wr_data;
            end
            if (hit(wr_addr, `ROCR_OFS_DEVID))
            begin
                dev_id <= wr_data;
            end
        end
    end

    // ************************************************
    // lock synchroniser
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            lock_sync <= 3'b000;
            lock_q <= 1'b0;
        end
        else
        begin
            lock_sync <= {lock_sync[1:0], lock_pin};
            if (lock_sync[1] == lock_sync[2])
            begin
                lock_q <= lock_sync[2];
            end
        end
    end

    // ************************************************
    // outputs and readback
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            return_channel_active <= 1'b1;
            out_enable_eff <= 1'b1;
            unlocked_pin_state <= 1'b1;
            fallback_osc_to_pixclk <= 1'b0;
            logic_reset_b <= 1'b1;
            regs_reset_pulse <= 1'b0;
            rd_data <= 8'h00;
        end
        else
        begin
            return_channel_active <= return_channel_on || gencfg[`ROCR_BIT_PT] || i2cctl[`ROCR_BIT_PTALL];
            out_enable_eff <= outcfg[`ROCR_BIT_OVR] ? outcfg[`ROCR_BIT_OE] : 1'b1;
            unlocked_pin_state <= outcfg[`ROCR_BIT_OVR] ? outcfg[`ROCR_BIT_OSS] : 1'b1;
            fallback_osc_to_pixclk <= outcfg[`ROCR_BIT_OSC] && !lock_q;
            // logic reset is held low while either pulse runs
            logic_reset_b <= !(req_full || req_keep || (state == ROCR_PULSE && pulse_cnt != 4'h0));
            regs_reset_pulse <= req_full;
            // reset bits never read back as 1 since they self-clear
            if (hit(rd_addr, `ROCR_OFS_RESET))
            begin
                rd_data <= {5'h00, return_channel_on, 2'b00} & `ROCR_MASK_RESET;
            end
            else if (hit(rd_addr, `ROCR_OFS_OUTCFG))
            begin
                rd_data <= {outcfg, 4'h0} & `ROCR_MASK_OUTCFG;
            end
            else if (hit(rd_addr, `ROCR_OFS_GENCFG))
            begin
                rd_data <= gencfg;
            end
            else if (hit(rd_addr, `ROCR_OFS_I2CCTL))
            begin
                rd_data <= i2cctl;
            end
            else if (hit(rd_addr, `ROCR_OFS_DEVID))
            begin
                rd_data <= dev_id;
            end
            else
            begin
                rd_data <= 8'h00;
            end
        end
    end
endmodule

/* File: sim/rocr_regs_chk.sv */
`timescale 1ns/1ps
module rocr_regs_chk #(
    parameter int PULSE_CYC = 2
)
(
    // clock, reset, write and read port
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic wr_remote,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic lock_pin,
    // block controls
    input wire logic return_channel_active,
    input wire logic out_enable_eff,
    input wire logic unlocked_pin_state,
    input wire logic fallback_osc_to_pixclk,
    input wire logic logic_reset_b,
    input wire logic regs_reset_pulse
);
    logic [1:0] lrb_q;
    logic [3:0] lo_cnt;
    logic [2:0] hi_cnt;
    // writes only count once no pulse window is open
    wire idle = logic_reset_b & lrb_q[0] & lrb_q[1];
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            lrb_q <= 2'h3;
            lo_cnt <= 4'h0;
            hi_cnt <= 3'h0;
        end
        else
        begin
            lrb_q <= {lrb_q[0], logic_reset_b};
            lo_cnt <= logic_reset_b ? 4'h0 : lo_cnt + 4'h1;
            hi_cnt <= !lock_pin ? 3'h0 : ((hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    full_pulse_a: assert property (idle && wr_en && wr_addr == 8'h01 && wr_data[1]
        |=> !logic_reset_b && regs_reset_pulse ##1 !regs_reset_pulse) else $error("full reset pulse wrong");
    keep_pulse_a: assert property (idle && wr_en && wr_addr == 8'h01 && wr_data[1:0] == 2'h1
        |=> !logic_reset_b && !regs_reset_pulse) else $error("keep reset pulse wrong");
    pulse_len_a: assert property ($rose(logic_reset_b) |-> lo_cnt == PULSE_CYC)
        else $error("reset pulse length wrong");
    rch_keep_a: assert property (idle && wr_en && wr_remote && wr_addr == 8'h01 && wr_data[1:0] == 2'h0
        && return_channel_active |=> ##1 return_channel_active) else $error("remote write cleared channel");
    oe_sel_a: assert property (idle && wr_en && wr_addr == 8'h02 |-> ##2
        out_enable_eff == ($past(wr_data[6], 2) ? $past(wr_data[7], 2) : 1'b1)) else $error("output enable wrong");
    oss_sel_a: assert property (idle && wr_en && wr_addr == 8'h02 |-> ##2
        unlocked_pin_state == ($past(wr_data[6], 2) ? $past(wr_data[4], 2) : 1'b1)) else $error("sleep state wrong");
    osc_lock_a: assert property (hi_cnt == 3'h7 |-> !fallback_osc_to_pixclk)
        else $error("fallback clock while locked");
    rst_rsv_a: assert property (rd_addr == 8'h01 |=> (rd_data & 8'hFB) == 8'h00)
        else $error("reset register bits not zero");
    cfg_rsv_a: assert property (rd_addr == 8'h02 |=> rd_data[3:0] == 4'h0)
        else $error("config reserved bits not zero");
    cover property (idle && wr_en && wr_addr == 8'h01 && wr_data[1]);
    cover property (idle && wr_en && wr_addr == 8'h01 && wr_data[1:0] == 2'h1);
    cover property ($rose(fallback_osc_to_pixclk));
endmodule
bind rocr_regs rocr_regs_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk_sys, .rst_b, .wr_en, .wr_remote, .wr_addr,
    .wr_data, .rd_addr, .rd_data, .lock_pin, .return_channel_active, .out_enable_eff, .unlocked_pin_state,
    .fallback_osc_to_pixclk, .logic_reset_b, .regs_reset_pulse);

/* File: sim/rocr_host.sv */
`timescale 1ns/1ps
module rocr_host #(
    parameter int PULSE_CYC = 2
)
(
    // clock
    input wire logic clk_sys,
    // write port
    output logic wr_en,
    output logic wr_remote,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    initial
    begin
        wr_en = 1'b0;
        wr_remote = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
    end
    task automatic put(input logic rem, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        wr_remote <= rem;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        // released bus must not look like the last write
        wr_addr <= ~a;
        wr_data <= ~d;
        if (a == 8'h01 && d[1:0] != 2'h0)
            repeat (PULSE_CYC + 2) @(posedge clk_sys);
    endtask
    task automatic oe_on(input logic [7:0] d);
        put(1'b0, 8'h02, d);
        put(1'b0, 8'h01, 8'h01);
    endtask
endmodule

/* File: sim/rocr_regs_tb.sv */
`timescale 1ns/1ps
module rocr_regs_tb;
    logic clk_sys, rst_b, lock_pin, wr_en, wr_remote;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, strap_dev_id, d;
    logic return_channel_active, out_enable_eff, unlocked_pin_state;
    logic fallback_osc_to_pixclk, logic_reset_b, regs_reset_pulse;
    int n_fail = 0;
    int check_count = 0;
    logic [7:0] lo_cyc = 8'h00;
    logic [7:0] rp_cyc = 8'h00;
    // cycles seen with the logic reset low and with the register reset pulse high
    always @(posedge clk_sys)
    begin
        if (rst_b)
        begin
            lo_cyc <= lo_cyc + 8'(!logic_reset_b);
            rp_cyc <= rp_cyc + 8'(regs_reset_pulse);
        end
    end
    rocr_regs #(.PULSE_CYC(2)) u_rocr_regs (.clk_sys, .rst_b, .wr_en, .wr_remote, .wr_addr, .wr_data,
        .rd_addr, .rd_data, .strap_dev_id, .lock_pin, .return_channel_active, .out_enable_eff,
        .unlocked_pin_state, .fallback_osc_to_pixclk, .logic_reset_b, .regs_reset_pulse);
    rocr_host #(.PULSE_CYC(2)) u_host (.clk_sys, .wr_en, .wr_remote, .wr_addr, .wr_data);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic eff(input logic [7:0] v, input int b);
        return v[6] ? v[b] : 1'b1;
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_addr <= a;
        @(posedge clk_sys);
        #1 cmp(rd_data, exp);
    endtask
    // outputs packed as channel, enable, sleep state, fallback
    task automatic st(input logic [7:0] exp);
        repeat (2) @(posedge clk_sys);
        #1 cmp({4'h0, return_channel_active, out_enable_eff, unlocked_pin_state, fallback_osc_to_pixclk}, exp);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #30000;
        n_fail++;
        test_done;
    end
    initial
    begin
        rst_b = 1'b0;
        lock_pin = 1'b1;
        rd_addr = 8'h00;
        strap_dev_id = 8'($urandom(32'hEAB1));
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(8'h01, 8'h04);
        rdc(8'h02, 8'h00);
        st(8'h0E);
        $display("defaults done");
        u_host.put(1'b1, 8'h01, 8'h00);
        rdc(8'h01, 8'h04);
        u_host.put(1'b0, 8'h01, 8'h00);
        st(8'h06);
        u_host.put(1'b0, 8'h03, 8'hF8);
        st(8'h0E);
        u_host.put(1'b0, 8'h03, 8'hF0);
        u_host.put(1'b1, 8'h05, 8'h9E);
        st(8'h0E);
        u_host.put(1'b0, 8'h05, 8'h1E);
        st(8'h06);
        $display("channel done");
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 8'h40 : 8'($urandom);
            u_host.put(i[0], 8'h02, d);
            rdc(8'h02, d & 8'hF0);
            st({5'h00, eff(d, 7), eff(d, 4), 1'b0});
        end
        $display("output config done");
        u_host.put(1'b0, 8'h02, 8'h20);
        lock_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        st(8'h07);
        lock_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        st(8'h06);
        $display("fallback done");
        u_host.oe_on(8'hD0);
        rdc(8'h02, 8'hD0);
        rdc(8'h01, 8'h00);
        cmp(lo_cyc, 8'h02);
        cmp(rp_cyc, 8'h00);
        u_host.put(1'b0, 8'h00, ~strap_dev_id);
        u_host.put(1'b0, 8'h01, 8'h02);
        rdc(8'h02, 8'h00);
        rdc(8'h00, strap_dev_id);
        rdc(8'h01, 8'h04);
        cmp(lo_cyc, 8'h04);
        cmp(rp_cyc, 8'h01);
        st(8'h0E);
        $display("digital resets done");
        test_done;
    end
endmodule
